// file: dv/fidrc_host.sv
// Host controller model that frames commands on the flash pins
`timescale 1ns/1ns
module fidrc_host (
    output logic            chipSelN,  // Select, active low
    output logic            serialClk, // Still between frames
    output logic      [3:0] ioIn,      // Lines to the device
    input  wire logic [3:0] ioOut,     // Device drive
    input  wire logic [3:0] ioOe,      // Device enables
    input  wire logic       quadMode   // Four-line mode
);
    // Idle pins before the first frame
    initial
    begin
        chipSelN = 1'b1;
        serialClk = 1'b0;
        ioIn = 4'h0;
    end
    // Send ntx bits then read nrx; released lines show the inverse of the last value
    task automatic xfer(input logic [31:0] tx, input int ntx, input int nrx,
                        output logic [31:0] rx);
        int w;
        rx = 32'h0;
        #3 chipSelN <= 1'b0;
        // Mode read after the edge so a change made on that edge is seen
        w = quadMode ? 4 : 1;
        for (int i = 0; i < ntx + nrx; i += w)
        begin
            ioIn <= i >= ntx ? ~ioIn : (quadMode ? tx[31-i -: 4]
                : {3'($urandom_range(7)), tx[31-i]});
            #40 serialClk <= 1'b1;
            // Sampled late in the high phase so the synchronised output has settled
            #40 rx = quadMode ? {rx[27:0], ioOut & ioOe} : {rx[30:0], ioOut[1] & ioOe[1]};
            serialClk <= 1'b0;
        end
        #40 chipSelN <= 1'b1;
        ioIn <= ~ioIn;
    endtask
endmodule // fidrc_host

// file: dv/fidrc_properties.sv
// Checker for the pin and register behaviour of the flash command block
`timescale 1ns/1ns
module fidrc_properties (
    input wire logic       clk,            // Clock
    input wire logic       rst,            // Reset
    input wire logic       chipSelN,       // Select
    input wire logic       serialClk,      // Link clock
    input wire logic [3:0] ioIn,           // Data in
    input wire logic       resetPinN,      // Reset pin
    input wire logic       quadMode,       // Quad mode
    input wire logic       hwProtect,      // Protect
    input wire logic       pgmEraseBusy,   // Busy
    input wire logic       enterPowerDown, // Sleep pulse
    input wire logic [3:0] ioOut,          // Drive
    input wire logic [3:0] ioOe,           // Enables
    input wire logic [7:0] statusReg,      // Status
    input wire logic [7:0] configReg,      // Config
    input wire logic       powerDown,      // Asleep
    input wire logic       standby         // Standby
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    property p_oe_mode; ioOe != 4'h0 |-> ioOe == (quadMode ? 4'hf : 4'h2); endproperty
    a_oe_mode: assert property (p_oe_mode) else $error("enable width wrong");
    property p_cs_off; chipSelN [*4] |=> ioOe == 4'h0; endproperty
    a_cs_off: assert property (p_cs_off) else $error("drive after deselect");
    // Six cycles back covers the pin synchroniser and output register
    property p_oe_cs; ioOe != 4'h0 |-> !$past(chipSelN, 6); endproperty
    a_oe_cs: assert property (p_oe_cs) else $error("drive without frame");
    property p_wip_end; $fell(statusReg[0]) |-> !statusReg[1]; endproperty
    a_wip_end: assert property (p_wip_end) else $error("latch kept");
    property p_wip_go; $rose(statusReg[0]) |-> chipSelN && $past(statusReg[1]) && !hwProtect;
    endproperty
    a_wip_go: assert property (p_wip_go) else $error("bad write start");
    property p_cfg; $changed(configReg) |-> $past(statusReg[1]); endproperty
    a_cfg: assert property (p_cfg) else $error("config changed unlatched");
    property p_pin; !resetPinN [*5] |-> !statusReg[1] && !powerDown && standby; endproperty
    a_pin: assert property (p_pin) else $error("reset pin ignored");
    // Release from sleep must wait out the release time with select high
    property p_wake; $fell(powerDown) && resetPinN |-> chipSelN && $past(chipSelN, 290);
    endproperty
    a_wake: assert property (p_wake) else $error("early wake");
endmodule // fidrc_properties

bind fidrc_top fidrc_properties chk_u (.clk(clk), .rst(rst), .chipSelN(chipSelN),
    .serialClk(serialClk), .ioIn(ioIn), .resetPinN(resetPinN), .quadMode(quadMode),
    .hwProtect(hwProtect), .pgmEraseBusy(pgmEraseBusy), .enterPowerDown(enterPowerDown),
    .ioOut(ioOut), .ioOe(ioOe), .statusReg(statusReg), .configReg(configReg),
    .powerDown(powerDown), .standby(standby));

// file: dv/testbench.sv
// Self-checking bench for the flash command block
`timescale 1ns/1ns
module testbench;
    logic        clk = 1'b0, rst = 1'b1, resetPinN = 1'b1, quadMode = 1'b0, hwProtect = 1'b0;
    logic        pgmEraseBusy = 1'b0, enterPowerDown = 1'b0, chipSelN, serialClk, powerDown;
    logic        standby, ok;
    logic [3:0]  ioIn, ioOut, ioOe;
    logic [7:0]  statusReg, configReg, sr = 8'h00, cr = 8'h00;
    logic [31:0] rx, d;
    int          bad_count = 0, comparisons = 0, cyc = 0, nb;

    fidrc_top #(.REG_WRITE_CYCLES(400)) dut_u (.clk(clk), .rst(rst), .chipSelN(chipSelN),
        .serialClk(serialClk), .ioIn(ioIn), .resetPinN(resetPinN), .quadMode(quadMode),
        .hwProtect(hwProtect), .pgmEraseBusy(pgmEraseBusy), .enterPowerDown(enterPowerDown),
        .ioOut(ioOut), .ioOe(ioOe), .statusReg(statusReg), .configReg(configReg),
        .powerDown(powerDown), .standby(standby));
    fidrc_host host_u (.chipSelN(chipSelN), .serialClk(serialClk), .ioIn(ioIn),
        .ioOut(ioOut), .ioOe(ioOe), .quadMode(quadMode));

    // 100 MHz clock
    initial
    begin
        forever #5 clk = ~clk;
    end
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic xf(input logic [31:0] tx, input int ntx, input int nrx);
        host_u.xfer(tx, ntx, nrx, rx);
        idle(6);
    endtask
    // Status after a write: bits 1:0 are read-only flags
    function automatic logic [7:0] sr_after(input logic [7:0] v);
        return {v[7:2], 2'b00};
    endfunction
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // Cycle ceiling cuts a hang short
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 40000)
        begin
            bad_count++;
            wrap_up();
        end
    end
    initial
    begin
        void'($urandom(78));
        idle(5);
        rst <= 1'b0;
        idle(4);
        chk("status rst", {statusReg, configReg, powerDown, standby}, 18'h1);
        xf(32'h9f000000, 8, 24);
        chk("id", rx, 32'h5a3c1e);
        xf(32'h9f000000, 8, 5);
        chk("id cut", rx, 32'h0b);
        for (int a = 0; a < 2; a++)
        begin
            d = $urandom;
            xf({8'h90, d[15:0], 7'h00, a[0]}, 32, 32);
            chk("maker dev", rx, a ? 32'h1e5a1e5a : 32'h5a1e5a1e);
        end
        // Writes: unlatched, 9 bits, protected, 16 bits, 8 bits
        for (int i = 0; i < 5; i++)
        begin
            d = $urandom;
            ok = i > 2;
            nb = i == 1 ? 9 : (i == 4 ? 8 : 16);
            hwProtect <= i == 2;
            if (i > 0)
                xf(32'h06000000, 8, 0);
            chk("latch", statusReg[1], i > 0);
            xf({8'h01, d[23:0]}, 8 + nb, 0);
            chk("wip", statusReg[0], ok);
            if (ok)
            begin
                xf(32'h05000000, 8, 8);
                chk("busy read", rx[1:0], 2'b11);
                sr = sr_after(d[23:16]);
                cr = i == 3 ? d[15:8] : cr;
            end
            idle(450);
            chk("sr", statusReg[7:2], sr[7:2]);
            chk("cr", configReg, cr);
            if (ok)
                chk("done", statusReg[1:0], 2'b00);
        end
        xf(32'h06000000, 8, 0);
        xf(32'h04000000, 8, 0);
        chk("disable", statusReg[1], 1'b0);
        pgmEraseBusy <= 1'b1;
        xf(32'h9f000000, 8, 24);
        chk("id busy", rx, 32'h0);
        xf(32'h05000000, 8, 16);
        chk("sr busy", rx, {16'h0, sr, sr});
        xf(32'h15000000, 8, 8);
        chk("cr busy", rx, cr);
        pgmEraseBusy <= 1'b0;
        // Sleep left by signature read, bare release, then reset pin
        for (int p = 0; p < 3; p++)
        begin
            xf(32'h06000000, 8, 0);
            enterPowerDown <= 1'b1;
            idle(1);
            enterPowerDown <= 1'b0;
            idle(3);
            chk("asleep", powerDown, 1'b1);
            xf(32'h9f000000, 8, 24);
            chk("id asleep", rx, 32'h0);
            if (p == 2)
            begin
                resetPinN <= 1'b0;
                idle(6);
                resetPinN <= 1'b1;
            end
            else
            begin
                xf(32'hab000000, 8, p ? 0 : 16);
                chk("sig", rx, p ? 32'h0 : 32'h1e1e);
                chk("delay", powerDown, 1'b1);
            end
            idle(320);
            chk("awake", {powerDown, standby, statusReg[1]}, {2'b01, p != 2});
        end
        quadMode <= 1'b1;
        xf(32'haf000000, 8, 24);
        chk("quad id", rx, 32'h5a3c1e);
        xf(32'h05000000, 8, 8);
        chk("quad sr", rx, sr);
        wrap_up();
    end
endmodule // testbench

// file: hdl/fidrc_pkg.sv
// Constants, opcodes, timing and state type of the flash ID and register command block
package fidrc_pkg;
    // Opcodes
    localparam logic [7:0] OP_THREE_BYTE_ID  = 8'h9f;
    localparam logic [7:0] OP_SIGNATURE      = 8'hab;
    localparam logic [7:0] OP_MAKER_DEV_ID   = 8'h90;
    localparam logic [7:0] OP_QUAD_ID        = 8'haf;
    localparam logic [7:0] OP_STATUS_READ    = 8'h05;
    localparam logic [7:0] OP_CONFIG_READ    = 8'h15;
    localparam logic [7:0] OP_REG_WRITE      = 8'h01;
    localparam logic [7:0] OP_WRITE_ENABLE   = 8'h06;
    localparam logic [7:0] OP_WRITE_DISABLE  = 8'h04;
    // Identity bytes: values are arbitrary
    localparam logic [7:0] MAKER_CODE        = 8'h5a;
    localparam logic [7:0] MEM_TYPE_CODE     = 8'h3c;
    localparam logic [7:0] DENSITY_CODE      = 8'h1e;
    // Phase lengths in bits
    localparam logic [4:0] OPCODE_BITS       = 5'h08;
    localparam logic [4:0] ADDR_PHASE_BITS   = 5'h18;
    localparam logic [4:0] WR_ONE_BYTE_BITS  = 5'h08;
    localparam logic [4:0] WR_TWO_BYTE_BITS  = 5'h10;
    localparam logic [4:0] WR_OVERRUN_BITS   = 5'h11;
    // Reset values
    localparam logic [7:0] STATUS_RESET      = 8'h00;
    localparam logic [7:0] CONFIG_RESET      = 8'h00;
    // Timing
    localparam int CLK_PERIOD_NS         = 10;
    localparam int RELEASE_TIME_ONE_NS   = 3000;
    localparam int RELEASE_TIME_TWO_NS   = 3000;
    localparam int REG_WRITE_TIME_NS     = 40000000;
    localparam int RELEASE_ONE_CYCLES    =
        (RELEASE_TIME_ONE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RELEASE_TWO_CYCLES    =
        (RELEASE_TIME_TWO_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int REG_WRITE_CYCLES      = (REG_WRITE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_OPCODE,
        ST_ADDR,
        ST_READOUT,
        ST_WRDATA,
        ST_LONE,
        ST_IGNORE
    } fidrc_state_e;
endpackage

// file: hdl/fidrc_sync.sv
// Two-stage synchroniser with a third stage kept for edge detection
`timescale 1ns/1ns
module fidrc_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,   // System clock
    input  wire logic         rst,   // Synchronous reset
    input  wire logic [W-1:0] async, // Inputs from outside the domain
    output logic      [W-1:0] lvl,   // Synchronised level
    output logic      [W-1:0] prv    // Level one cycle earlier
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
    } fidrc_sync_s;

    fidrc_sync_s q;
    fidrc_sync_s d;

    // Stage one is read only by stage two
    always_comb
    begin
        d    = q;
        d.s1 = async;
        d.s2 = q.s1;
        d.s3 = q.s2;
    end

    // Select and reset pins idle high, so reset to ones avoids a false edge on them
    always_ff @(posedge clk)
    begin
        if (rst)
            q <= '1;
        else
            q <= d;
    end

    assign lvl = q.s2;
    assign prv = q.s3;
endmodule // fidrc_sync

// file: hdl/fidrc_timer.sv
// Down-counter that times self-timed write and power-down release cycles
`timescale 1ns/1ns
module fidrc_timer (
    input  wire logic clk,       // System clock
    input  wire logic rst,       // Synchronous reset
    fidrc_timer_if.tmr tif       // Start and done handshake
);
    typedef struct packed {
        logic [31:0] cnt;
        logic        busy;
        logic        done;
    } fidrc_timer_s;

    fidrc_timer_s q;
    fidrc_timer_s d;

    // Load on start; done is a single-cycle pulse at expiry
    always_comb
    begin
        d      = q;
        d.done = 1'b0;
        if (tif.start)
        begin
            d.cnt  = (tif.load == 32'h0) ? 32'h1 : tif.load;
            d.busy = 1'b1;
        end
        else if (q.busy)
        begin
            if (q.cnt == 32'h1)
            begin
                d.busy = 1'b0;
                d.done = 1'b1;
            end
            d.cnt = q.cnt - 32'h1;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            q <= '0;
        else
            q <= d;
    end

    assign tif.busy = q.busy;
    assign tif.done = q.done;
endmodule // fidrc_timer

// file: hdl/fidrc_timer_if.sv
// Start and completion signals between command logic and the cycle timer
`timescale 1ns/1ns
interface fidrc_timer_if;
    logic        start;
    logic [31:0] load;
    logic        busy;
    logic        done;
    modport ctl (output start, output load, input busy, input done);
    modport tmr (input start, input load, output busy, output done);
endinterface // fidrc_timer_if

// file: hdl/fidrc_top.sv
// Serial flash command interpreter for ID reads, power-down release and registers
`timescale 1ns/1ns
module fidrc_top #(
    parameter int unsigned REG_WRITE_CYCLES = fidrc_pkg::REG_WRITE_CYCLES
) (
    input  wire logic       clk,            // System clock, 100 MHz
    input  wire logic       rst,            // Synchronous reset, active high
    input  wire logic       chipSelN,       // Chip select pin, active low
    input  wire logic       serialClk,      // Serial clock pin from host
    input  wire logic [3:0] ioIn,           // Data pins as seen on the wire
    input  wire logic       resetPinN,      // Hardware reset pin, active low
    input  wire logic       quadMode,       // Quad command mode selected
    input  wire logic       hwProtect,      // Hardware protected mode active
    input  wire logic       pgmEraseBusy,   // Program or erase operation running
    input  wire logic       enterPowerDown, // Pulse: enter deep power-down
    output logic      [3:0] ioOut,          // Data pin drive values
    output logic      [3:0] ioOe,           // Data pin output enables
    output logic      [7:0] statusReg,      // Status register
    output logic      [7:0] configReg,      // Configuration register
    output logic            powerDown,      // Deep power-down active
    output logic            standby         // Standby reached
);
    typedef struct packed {
        fidrc_pkg::fidrc_state_e st;
        logic [4:0]  bitCnt;
        logic [7:0]  op;
        logic [15:0] inShift;
        logic        addrSel;
        logic [7:0]  outShift;
        logic [2:0]  outLeft;
        logic [1:0]  byteIdx;
        logic        fullByte;
        logic [3:0]  ioOut;
        logic [3:0]  ioOe;
        logic [7:0]  sr;
        logic [7:0]  cr;
        logic        write_enable_latch;
        logic        write_in_progress;
        logic        dpd;
        logic        releasing;
        logic        standby;
        logic        tmrStart;
        logic [31:0] tmrLoad;
    } fidrc_top_s;

    fidrc_top_s q;
    fidrc_top_s d;

    logic [6:0] syncLvl;
    logic [6:0] syncPrv;
    logic       csRise;
    logic       csFall;
    logic       clkRise;
    logic       clkFall;
    logic       rstPinLow;
    logic [3:0] ioS;
    logic       busy;
    logic [7:0] newOp;
    logic [4:0] newCnt;
    logic [7:0] curByte;

    fidrc_timer_if tif ();

    // Reset, clock, select and data pins cross into the clock domain before use
    fidrc_sync #(
        .W (7)
    ) u_sync (
        .clk   (clk),
        .rst   (rst),
        .async ({resetPinN, serialClk, chipSelN, ioIn}),
        .lvl   (syncLvl),
        .prv   (syncPrv)
    );

    fidrc_timer u_timer (
        .clk (clk),
        .rst (rst),
        .tif (tif)
    );

    // Edges of the synchronised pins
    assign ioS       = syncLvl[3:0];
    assign csFall    = ~syncLvl[4] & syncPrv[4];
    assign csRise    = syncLvl[4] & ~syncPrv[4];
    assign clkRise   = syncLvl[5] & ~syncPrv[5];
    assign clkFall   = ~syncLvl[5] & syncPrv[5];
    assign rstPinLow = ~syncLvl[6];

    // Byte presented by each read command at a given position
    function automatic logic [7:0] pickByte(
        input logic [7:0] op,
        input logic [1:0] idx,
        input logic       sel,
        input logic [7:0] sr,
        input logic [7:0] cr
    );
        logic [7:0] b;
        b = fidrc_pkg::DENSITY_CODE;
        case (op)
            fidrc_pkg::OP_THREE_BYTE_ID,
            fidrc_pkg::OP_QUAD_ID:
                b = (idx == 2'h0) ? fidrc_pkg::MAKER_CODE :
                    (idx == 2'h1) ? fidrc_pkg::MEM_TYPE_CODE : fidrc_pkg::DENSITY_CODE;
            fidrc_pkg::OP_MAKER_DEV_ID:
                b = (idx[0] ^ sel) ? fidrc_pkg::DENSITY_CODE : fidrc_pkg::MAKER_CODE;
            fidrc_pkg::OP_STATUS_READ:
                b = sr;
            fidrc_pkg::OP_CONFIG_READ:
                b = cr;
            default:
                b = fidrc_pkg::DENSITY_CODE;
        endcase
        return b;
    endfunction

    // Quad mode moves a nibble per clock, serial mode one bit
    always_comb
    begin
        if (quadMode)
        begin
            newOp  = {q.op[3:0], ioS};
            newCnt = q.bitCnt + 5'h04;
        end
        else
        begin
            newOp  = {q.op[6:0], ioS[0]};
            newCnt = q.bitCnt + 5'h01;
        end
    end

    assign busy    = q.write_in_progress | pgmEraseBusy;
    assign curByte = pickByte(q.op, q.byteIdx, q.addrSel, q.sr, q.cr);

    // Command sequencing, register updates and power-down tracking
    always_comb
    begin
        d          = q;
        d.tmrStart = 1'b0;

        if (csRise)
        begin
            // Data lines released on the clock after the synchronised select rise is seen
            d.st   = fidrc_pkg::ST_IDLE;
            d.ioOe = 4'h0;
            if (q.st == fidrc_pkg::ST_LONE && q.bitCnt == fidrc_pkg::OPCODE_BITS)
            begin
                if (q.op == fidrc_pkg::OP_WRITE_ENABLE)
                    d.write_enable_latch = 1'b1;
                else if (q.op == fidrc_pkg::OP_WRITE_DISABLE)
                    d.write_enable_latch = 1'b0;
            end
            if (q.st == fidrc_pkg::ST_WRDATA)
            begin
                // Only exact byte boundaries commit the write
                if (q.bitCnt == fidrc_pkg::WR_ONE_BYTE_BITS)
                begin
                    d.sr[7:2]  = q.inShift[7:2];
                    d.write_in_progress      = 1'b1;
                    d.tmrStart = 1'b1;
                    d.tmrLoad  = REG_WRITE_CYCLES;
                end
                else if (q.bitCnt == fidrc_pkg::WR_TWO_BYTE_BITS)
                begin
                    d.sr[7:2]  = q.inShift[15:10];
                    d.cr       = q.inShift[7:0];
                    d.write_in_progress      = 1'b1;
                    d.tmrStart = 1'b1;
                    d.tmrLoad  = REG_WRITE_CYCLES;
                end
            end
            if ((q.st == fidrc_pkg::ST_READOUT || q.st == fidrc_pkg::ST_LONE)
                && q.op == fidrc_pkg::OP_SIGNATURE)
            begin
                if (q.dpd && !q.releasing)
                begin
                    // A signature read out picks RELEASE_TWO_CYCLES, the same length as the bare-release delay
                    d.releasing = 1'b1;
                    d.tmrStart  = 1'b1;
                    d.tmrLoad   = q.fullByte ? 32'(fidrc_pkg::RELEASE_TWO_CYCLES)
                                             : 32'(fidrc_pkg::RELEASE_ONE_CYCLES);
                end
                else if (!q.dpd)
                    d.standby = 1'b1;
            end
        end
        else if (csFall && q.st == fidrc_pkg::ST_IDLE)
        begin
            d.st       = fidrc_pkg::ST_OPCODE;
            d.bitCnt   = 5'h00;
            d.op       = 8'h00;
            d.fullByte = 1'b0;
        end
        else if (clkRise)
        begin
            unique case (q.st)
                fidrc_pkg::ST_OPCODE:
                begin
                    d.op     = newOp;
                    d.bitCnt = newCnt;
                    if (newCnt == fidrc_pkg::OPCODE_BITS)
                    begin
                        d.bitCnt  = 5'h00;
                        d.outLeft = 3'h0;
                        d.byteIdx = 2'h0;
                        d.st      = fidrc_pkg::ST_IGNORE;
                        if (q.dpd)
                        begin
                            // Only the release opcode wakes a sleeping device
                            if (newOp == fidrc_pkg::OP_SIGNATURE && !busy && !q.releasing)
                                d.st = fidrc_pkg::ST_READOUT;
                        end
                        else if (newOp == fidrc_pkg::OP_STATUS_READ
                                 || newOp == fidrc_pkg::OP_CONFIG_READ)
                            d.st = fidrc_pkg::ST_READOUT;
                        else if (!busy)
                        begin
                            // Busy cycles leave every other opcode undecoded
                            unique case (newOp)
                                fidrc_pkg::OP_THREE_BYTE_ID:
                                    if (!quadMode)
                                        d.st = fidrc_pkg::ST_READOUT;
                                fidrc_pkg::OP_QUAD_ID:
                                    if (quadMode)
                                        d.st = fidrc_pkg::ST_READOUT;
                                fidrc_pkg::OP_MAKER_DEV_ID:
                                    if (!quadMode)
                                        d.st = fidrc_pkg::ST_ADDR;
                                fidrc_pkg::OP_SIGNATURE:
                                    d.st = fidrc_pkg::ST_READOUT;
                                fidrc_pkg::OP_REG_WRITE:
                                    if (q.write_enable_latch && !hwProtect)
                                        d.st = fidrc_pkg::ST_WRDATA;
                                fidrc_pkg::OP_WRITE_ENABLE,
                                fidrc_pkg::OP_WRITE_DISABLE:
                                begin
                                    d.st     = fidrc_pkg::ST_LONE;
                                    d.bitCnt = fidrc_pkg::OPCODE_BITS;
                                end
                                default:
                                    d.st = fidrc_pkg::ST_IGNORE;
                            endcase
                        end
                    end
                end
                fidrc_pkg::ST_ADDR:
                begin
                    // Dummy bytes shift through; only the last bit steers order
                    d.bitCnt  = q.bitCnt + 5'h01;
                    d.addrSel = ioS[0];
                    if (q.bitCnt + 5'h01 == fidrc_pkg::ADDR_PHASE_BITS)
                        d.st = fidrc_pkg::ST_READOUT;
                end
                fidrc_pkg::ST_WRDATA:
                begin
                    d.inShift = quadMode ? {q.inShift[11:0], ioS} : {q.inShift[14:0], ioS[0]};
                    // Saturate so an overlong write can never look valid
                    d.bitCnt  = (newCnt > fidrc_pkg::WR_TWO_BYTE_BITS)
                                ? fidrc_pkg::WR_OVERRUN_BITS : newCnt;
                end
                fidrc_pkg::ST_READOUT:
                    if (q.outLeft == 3'h0 && q.ioOe != 4'h0)
                        d.fullByte = 1'b1;
                fidrc_pkg::ST_LONE:
                    d.st = fidrc_pkg::ST_IGNORE;
                default:
                    d.st = q.st;
            endcase
        end
        else if (clkFall && q.st == fidrc_pkg::ST_READOUT)
        begin
            // Falling edges shift data out, most significant part first
            if (q.outLeft == 3'h0)
            begin
                // Maker/device codes alternate in pairs; ID reads cycle three bytes
                if (q.byteIdx == 2'h2 || (q.op == fidrc_pkg::OP_MAKER_DEV_ID && q.byteIdx[0]))
                    d.byteIdx = 2'h0;
                else
                    d.byteIdx = q.byteIdx + 2'h1;
                if (quadMode)
                begin
                    d.ioOut    = curByte[7:4];
                    d.ioOe     = 4'hf;
                    d.outShift = {curByte[3:0], 4'h0};
                    d.outLeft  = 3'h1;
                end
                else
                begin
                    d.ioOut    = {2'b00, curByte[7], 1'b0};
                    d.ioOe     = 4'h2;
                    d.outShift = {curByte[6:0], 1'b0};
                    d.outLeft  = 3'h7;
                end
            end
            else
            begin
                d.outLeft = q.outLeft - 3'h1;
                if (quadMode)
                begin
                    d.ioOut    = q.outShift[7:4];
                    d.outShift = {q.outShift[3:0], 4'h0};
                end
                else
                begin
                    d.ioOut    = {2'b00, q.outShift[7], 1'b0};
                    d.outShift = {q.outShift[6:0], 1'b0};
                end
            end
        end

        // Timed cycle completion
        if (tif.done)
        begin
            if (q.write_in_progress)
            begin
                d.write_in_progress = 1'b0;
                d.write_enable_latch = 1'b0;
            end
            if (q.releasing)
            begin
                d.releasing = 1'b0;
                d.dpd       = 1'b0;
                d.standby   = 1'b1;
            end
        end

        // Power-down entry is requested by logic outside this block
        if (enterPowerDown && !busy)
        begin
            d.dpd     = 1'b1;
            d.standby = 1'b0;
        end

        // Reset pin wins over everything else it touches
        if (rstPinLow)
        begin
            d.write_enable_latch       = 1'b0;
            d.dpd       = 1'b0;
            d.releasing = 1'b0;
            d.standby   = 1'b1;
        end

        d.sr[1:0] = {d.write_enable_latch, d.write_in_progress};
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            q         <= '0;
            q.st      <= fidrc_pkg::ST_IDLE;
            q.sr      <= fidrc_pkg::STATUS_RESET;
            q.cr      <= fidrc_pkg::CONFIG_RESET;
            q.standby <= 1'b1;
        end
        else
            q <= d;
    end

    // Timer handshake and registered outputs
    assign tif.start = q.tmrStart;
    assign tif.load  = q.tmrLoad;
    assign ioOut     = q.ioOut;
    assign ioOe      = q.ioOe;
    assign statusReg = q.sr;
    assign configReg = q.cr;
    assign powerDown = q.dpd;
    assign standby   = q.standby;
endmodule // fidrc_top
